// ===== hw/pis_cfg.svh
// timing counts and fixed constants of the priority interrupt sequencer
`ifndef PIS_CFG_SVH
`define PIS_CFG_SVH

// clock and processor cycle, in nanoseconds as printed
`define PIS_CLK_NS 25
`define PIS_CYCLE_NS 1600
// one quarter cycle in ref_clk periods (16 at 40 MHz)
`define PIS_QTR_CLKS ((`PIS_CYCLE_NS / `PIS_CLK_NS) / 4)

// instruction lengths, in quarter cycles
`define PIS_Q_CYCLE 4
`define PIS_Q_MEMREF_BASE 8
`define PIS_Q_SCAN_BASE 8
`define PIS_Q_SHIFT_BASE 5
`define PIS_Q_PER_PLACE 2
`define PIS_Q_AUTO_IO 18
`define PIS_Q_STRETCH 1

// reset values
`define PIS_RST_ENABLE 1'b0
`define PIS_RST_PF_ENABLE 1'b0

// request vector positions, highest priority first
`define PIS_SRC_POWER_FAIL 0
`define PIS_SRC_CONSOLE 1
`define PIS_SRC_LINE_ONE 2
`define PIS_SRC_LINE_TWO 3
`define PIS_SRC_PROTECT 4
`define PIS_SRC_RTC_CLOCK 5
`define PIS_SRC_RTC_SYNC 6
`define PIS_SRC_SHARED 7
`define PIS_NUM_SRC 12

`endif

// ===== hw/pis_pkg.sv
// types of the priority interrupt sequencer
package pis_pkg;

   // instruction classes reported by the core at instruction start
   typedef enum logic [3:0] {
      PIS_OP_OTHER,
      PIS_OP_MEMREF,
      PIS_OP_JST,
      PIS_OP_IMS,
      PIS_OP_SCAN,
      PIS_OP_SHIFT,
      PIS_OP_AUTO_IO,
      PIS_OP_ENABLE,
      PIS_OP_DISABLE,
      PIS_OP_PFE,
      PIS_OP_INHIBIT
   } pis_op_type;

   typedef enum logic {
      PIS_IDLE,
      PIS_EXEC
   } pis_phase_type;

   // whole state of the sequencer
   typedef struct packed {
      logic [12:0] s1;
      logic [12:0] s2;
      logic [12:0] s3;
      logic [12:0] pin;
      pis_phase_type st;
      logic [19:0] qtr;
      logic [3:0] sub;
      pis_op_type op;
      logic is_int;
      logic int_next;
      logic en;
      logic pf_en;
      logic [7:0] defer;
      logic prot_pend;
      logic trap_pend;
      logic instr_end;
      logic take;
      logic [3:0] src;
      logic [4:0] shared_grant;
      logic echo;
   } pis_state_type;

endpackage

// ===== hw/pis_sequencer.sv
// interrupt recognition and priority sequencer, one instruction at a time
// Notes on behaviour
// - recognise only at instruction boundaries
// - highest priority pending request wins
// - memory reference: two cycles plus indirect levels
// - scan: two cycles plus one per word
// - long sixteen place shift completes first
// - enable lets one more instruction run
// - power fail enable defers like enable
// - disable blocks from its own execution
// - counted inhibit blocks that many instructions
// - one main instruction after interrupt instruction
// - jump and store interrupt clears enable
// - auto transfer takes four and half cycles
// - interrupt instruction stretched one quarter cycle
// - increment skip gets one more quarter
// - power fail highest, own line
// - console and trap share second level
// - line one third, line two fourth
// - protected write raises fifth level request
// - two clock interrupts, equal, below protect
// - shared slots ranked E200, E100, F100, F200
// - nothing recognised when halted or stopped
// - interrupt instruction runs without counter increment
// - increment skip at zero as the interrupt instruction echoes, no skip
`include "pis_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module pis_sequencer
   import pis_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // instruction handshake from the core
   input wire logic instr_start,
   input wire pis_op_type instr_op,
   input wire logic [2:0] indirect_levels,
   input wire logic [15:0] scan_words,
   input wire logic [4:0] shift_places,
   input wire logic [7:0] inhibit_count,
   input wire logic ims_zero,
   input wire logic trap_op,
   // configuration and protection, core side
   input wire logic pf_separate,
   input wire logic prot_enabled,
   input wire logic prot_write,
   // request and control pins
   input wire logic power_fail_req,
   input wire logic console_req,
   input wire logic dedicated_line_one,
   input wire logic dedicated_line_two,
   input wire logic rtc_clock_req,
   input wire logic rtc_sync_req,
   input wire logic [4:0] shared_request_line,
   input wire logic halt_pin,
   input wire logic stop_pin,
   // results
   output logic busy,
   output logic instr_end,
   output logic int_take,
   output logic [3:0] int_source,
   output logic [4:0] shared_grant,
   output logic int_instr,
   output logic echo,
   output logic intr_enabled
);

   // ****************************************************************
   // state and next state
   // ****************************************************************
   pis_state_type st_r;
   pis_state_type st_nxt;
   logic [19:0] base_q;
   logic [`PIS_NUM_SRC-1:0] req;
   logic [`PIS_NUM_SRC-1:0] gated;
   logic any_req;
   logic [3:0] best;
   logic [7:0] new_def;
   logic blk_op;
   logic allow;

   // length of the reported instruction in quarter cycles
   function automatic logic [19:0] op_len(input pis_op_type op, input logic [2:0] ind,
                                          input logic [15:0] words, input logic [4:0] pl);
      logic [19:0] n;
      n = 20'(`PIS_Q_CYCLE);
      unique case (op)
         PIS_OP_MEMREF, PIS_OP_JST, PIS_OP_IMS:
            n = 20'(`PIS_Q_MEMREF_BASE) + 20'(`PIS_Q_CYCLE) * 20'(ind);
         PIS_OP_SCAN:
            n = 20'(`PIS_Q_SCAN_BASE) + 20'(`PIS_Q_CYCLE) * 20'(words);
         PIS_OP_SHIFT:
            n = 20'(`PIS_Q_SHIFT_BASE) + 20'(`PIS_Q_PER_PLACE) * 20'(pl);
         PIS_OP_AUTO_IO:
            n = 20'(`PIS_Q_AUTO_IO);
         PIS_OP_OTHER, PIS_OP_ENABLE, PIS_OP_DISABLE, PIS_OP_PFE, PIS_OP_INHIBIT:
            n = 20'(`PIS_Q_CYCLE);
      endcase
      if (n == 20'h0)
      begin
         n = 20'h1;
      end
      return n;
   endfunction

   // ****************************************************************
   // request vector and priority choice
   // ****************************************************************
   // pin requests are levels held by their sources, protect and trap are latched here; nothing is consumed on a loss
   always_comb
   begin
      req = '0;
      req[`PIS_SRC_POWER_FAIL] = st_r.pin[0];
      req[`PIS_SRC_CONSOLE] = st_r.pin[1] | st_r.trap_pend;
      req[`PIS_SRC_LINE_ONE] = st_r.pin[2];
      req[`PIS_SRC_LINE_TWO] = st_r.pin[3];
      req[`PIS_SRC_PROTECT] = st_r.prot_pend;
      req[`PIS_SRC_RTC_CLOCK] = st_r.pin[4];
      req[`PIS_SRC_RTC_SYNC] = st_r.pin[5];
      // bit 0 of the shared line is the teleprinter, then slots in order
      req[`PIS_NUM_SRC-1:`PIS_SRC_SHARED] = st_r.pin[10:6];
      gated = req & {`PIS_NUM_SRC{st_r.en}};
      gated[`PIS_SRC_POWER_FAIL] = req[`PIS_SRC_POWER_FAIL] &
                                   (pf_separate ? st_r.pf_en : st_r.en);
   end

   // lowest index wins; the two clock lines tie, clock goes before sync
   always_comb
   begin
      best = 4'h0;
      any_req = 1'b0;
      for (int i = `PIS_NUM_SRC - 1; i >= 0; i--)
      begin
         if (gated[i])
         begin
            best = 4'(i);
            any_req = 1'b1;
         end
      end
   end

   // ****************************************************************
   // deferral bookkeeping at the boundary
   // ****************************************************************
   always_comb
   begin
      base_q = op_len(instr_op, indirect_levels, scan_words, shift_places);
      blk_op = 1'b1;
      new_def = (st_r.defer != 8'h0) ? st_r.defer - 8'h1 : 8'h0;
      if (st_r.is_int)
      begin
         new_def = 8'h1;
      end
      else if (st_r.op == PIS_OP_ENABLE || st_r.op == PIS_OP_PFE)
      begin
         new_def = 8'h1;
      end
      else if (st_r.op == PIS_OP_INHIBIT)
      begin
         new_def = inhibit_count;
      end
      else if (st_r.op != PIS_OP_DISABLE)
      begin
         blk_op = 1'b0;
      end
      // halt and stop come from synchronised pins
      allow = !blk_op && new_def == 8'h0 && !st_r.pin[11] && !st_r.pin[12];
   end

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb
   begin
      st_nxt = st_r;
      // three stage pin synchroniser, a change counts once stages two and three agree
      st_nxt.s1 = {stop_pin, halt_pin, shared_request_line, rtc_sync_req, rtc_clock_req,
                   dedicated_line_two, dedicated_line_one, console_req, power_fail_req};
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      st_nxt.pin = (~(st_r.s2 ^ st_r.s3) & st_r.s3) | ((st_r.s2 ^ st_r.s3) & st_r.pin);
      st_nxt.instr_end = 1'b0;
      st_nxt.take = 1'b0;
      st_nxt.echo = 1'b0;
      st_nxt.shared_grant = 5'h0;
      unique case (st_r.st)
         PIS_IDLE:
         begin
            if (instr_start)
            begin
               st_nxt.st = PIS_EXEC;
               st_nxt.op = instr_op;
               st_nxt.is_int = st_r.int_next;
               st_nxt.int_next = 1'b0;
               st_nxt.sub = 4'(`PIS_QTR_CLKS - 1);
               st_nxt.qtr = base_q;
               if (st_r.int_next)
               begin
                  // the extra quarter carries the interrupt address generation
                  st_nxt.qtr = base_q + 20'(`PIS_Q_STRETCH);
                  if (instr_op == PIS_OP_IMS)
                  begin
                     st_nxt.qtr = base_q + 20'(2 * `PIS_Q_STRETCH);
                  end
               end
               if (instr_op == PIS_OP_DISABLE)
               begin
                  st_nxt.en = 1'b0;
               end
            end
         end
         PIS_EXEC:
         begin
            // requests during execution only wait for the end
            st_nxt.sub = st_r.sub - 4'h1;
            if (st_r.sub == 4'h0)
            begin
               st_nxt.sub = 4'(`PIS_QTR_CLKS - 1);
               st_nxt.qtr = st_r.qtr - 20'h1;
               if (st_r.qtr == 20'h1)
               begin
                  st_nxt.st = PIS_IDLE;
                  st_nxt.instr_end = 1'b1;
                  // flag drops at the boundary so int_instr can come straight from it
                  st_nxt.is_int = 1'b0;
                  st_nxt.defer = new_def;
                  if (st_r.op == PIS_OP_ENABLE)
                  begin
                     st_nxt.en = 1'b1;
                  end
                  if (st_r.op == PIS_OP_PFE)
                  begin
                     st_nxt.pf_en = 1'b1;
                  end
                  if (st_r.is_int && st_r.op == PIS_OP_JST)
                  begin
                     st_nxt.en = 1'b0;
                  end
                  st_nxt.echo = st_r.is_int && st_r.op == PIS_OP_IMS && ims_zero;
                  if (allow && any_req)
                  begin
                     st_nxt.take = 1'b1;
                     st_nxt.src = best;
                     st_nxt.int_next = 1'b1;
                     if (best >= 4'(`PIS_SRC_SHARED))
                     begin
                        st_nxt.shared_grant = 5'h1 << (best - 4'(`PIS_SRC_SHARED));
                     end
                  end
               end
            end
         end
      endcase
      // latched sources clear on service, a new event in that cycle wins
      if (st_nxt.take && st_nxt.src == 4'(`PIS_SRC_PROTECT))
      begin
         st_nxt.prot_pend = 1'b0;
      end
      if (st_nxt.take && st_nxt.src == 4'(`PIS_SRC_CONSOLE))
      begin
         st_nxt.trap_pend = 1'b0;
      end
      if (prot_enabled && prot_write)
      begin
         st_nxt.prot_pend = 1'b1;
      end
      if (trap_op)
      begin
         st_nxt.trap_pend = 1'b1;
      end
   end

   // ****************************************************************
   // state register
   // ****************************************************************
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         st_r <= '0;
         st_r.en <= `PIS_RST_ENABLE;
         st_r.pf_en <= `PIS_RST_PF_ENABLE;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // outputs straight from the state register
   assign busy = (st_r.st == PIS_EXEC);
   assign instr_end = st_r.instr_end;
   assign int_take = st_r.take;
   assign int_source = st_r.src;
   assign shared_grant = st_r.shared_grant;
   assign int_instr = st_r.is_int;
   assign echo = st_r.echo;
   assign intr_enabled = st_r.en;

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!nrst);

   boundary_only_a: assert property (st_r.take |-> st_r.instr_end && $past(busy))
      else $error("recognition away from a boundary");
   priority_pick_a: assert property (st_r.take |-> st_r.src == $past(best))
      else $error("lower priority request chosen");
   ein_defer_a: assert property (st_r.instr_end && st_r.op == PIS_OP_ENABLE |-> !st_r.take)
      else $error("recognition right after enable");
   din_block_a: assert property ((busy && st_r.op == PIS_OP_DISABLE) |-> !st_r.en)
      else $error("enable still set during disable");
   inhibit_hold_a: assert property ($past(st_r.defer) > 8'h1 && st_r.instr_end |-> !st_r.take)
      else $error("recognition inside counted inhibit");
   // a take may never close the interrupt instruction itself
   int_gap_a: assert property (st_r.take |-> !$past(st_r.is_int))
      else $error("no main instruction between interrupts");
   jst_clear_a: assert property (st_r.instr_end && $past(st_r.is_int) &&
                                 st_r.op == PIS_OP_JST |-> !st_r.en && !st_r.take)
      else $error("jump and store left interrupts enabled");
   stretch_a: assert property (!busy && instr_start && st_r.int_next &&
                               instr_op != PIS_OP_IMS |=> st_r.qtr == $past(base_q) + 20'h1)
      else $error("interrupt instruction not stretched one quarter");
   ims_stretch_a: assert property (!busy && instr_start && st_r.int_next &&
                                   instr_op == PIS_OP_IMS |=> st_r.qtr == $past(base_q) + 20'h2)
      else $error("increment skip not stretched two quarters");
   // a grant on the shared line only ever goes with a shared source being taken
   grant_shared_a: assert property (st_r.shared_grant != 5'h0 |-> st_r.take && st_r.src >= 4'h7)
      else $error("shared grant without a shared take");
   halt_block_a: assert property (st_r.take |-> !$past(st_r.pin[11]) && !$past(st_r.pin[12]))
      else $error("recognition while halted or stopped");

   take_c: cover property (st_r.take);
   echo_c: cover property (st_r.echo);
   pf_take_c: cover property (st_r.take && st_r.src == 4'h0);
   shared_c: cover property (st_r.shared_grant != 5'h0);
   trap_c: cover property (st_r.take && st_r.src == 4'h1);

endmodule

`default_nettype wire

// ===== testbench/pis_periph_model.sv
// model of the peripherals and options raising requests into the sequencer
`timescale 1ns/100ps
`default_nettype none

module pis_periph_model
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // commands from the bench and answers from the sequencer
   input wire logic [11:0] raise,
   input wire logic int_take,
   input wire logic [3:0] int_source,
   // request levels, in the sequencer's source order
   output logic [11:0] req
);
   logic [11:0] req_r;
   logic [11:0] served;

   // a request is held until its own source is served, never dropped early
   assign served = int_take ? (12'h001 << int_source) : 12'h000;

   // the teleprinter sits on shared bit 0, slots follow in chassis order
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
         req_r <= 12'h000;
      else
         req_r <= (req_r & ~served) | raise;
   end

   assign req = req_r;
endmodule

`default_nettype wire

// ===== testbench/tb_priority_interrupt_sequencer.sv
// self-checking bench for the priority interrupt sequencer
`timescale 1ns/100ps
`default_nettype none

module tb_priority_interrupt_sequencer
   import pis_pkg::*;
;
   logic ref_clk, nrst, instr_start, ims_zero, trap_op, pf_separate;
   logic prot_enabled, prot_write, halt_pin, stop_pin;
   pis_op_type instr_op;
   logic [2:0] indirect_levels;
   logic [15:0] scan_words;
   logic [4:0] shift_places, shared_grant, last_grant;
   logic [7:0] inhibit_count;
   logic [11:0] raise, req;
   logic busy, instr_end, int_take, int_instr, echo, intr_enabled, last_ii, last_echo;
   logic [3:0] int_source;
   int n_errors, samples_checked;

   pis_sequencer pis_sequencer_inst (.ref_clk(ref_clk), .nrst(nrst),
      .instr_start(instr_start), .instr_op(instr_op), .indirect_levels(indirect_levels),
      .scan_words(scan_words), .shift_places(shift_places), .inhibit_count(inhibit_count),
      .ims_zero(ims_zero), .trap_op(trap_op), .pf_separate(pf_separate),
      .prot_enabled(prot_enabled), .prot_write(prot_write), .power_fail_req(req[0]),
      .console_req(req[1]), .dedicated_line_one(req[2]), .dedicated_line_two(req[3]),
      .rtc_clock_req(req[5]), .rtc_sync_req(req[6]), .shared_request_line(req[11:7]),
      .halt_pin(halt_pin), .stop_pin(stop_pin), .busy(busy), .instr_end(instr_end),
      .int_take(int_take), .int_source(int_source), .shared_grant(shared_grant),
      .int_instr(int_instr), .echo(echo), .intr_enabled(intr_enabled));

   pis_periph_model pis_periph_model_inst (.ref_clk(ref_clk), .nrst(nrst), .raise(raise),
      .int_take(int_take), .int_source(int_source), .req(req));

   // 40 mhz clock
   always #12.5 ref_clk = ~ref_clk;

   // ****************************************
   // shared tasks
   // ****************************************
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("FAIL %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   // one instruction; exp is the source expected at its boundary, -1 for none
   task automatic run(input pis_op_type op, input int ql, input int exp);
      logic [31:0] n;
      logic early;
      n = 0;
      early = 1'b0;
      instr_op = op;
      instr_start = 1'b1;
      @(negedge ref_clk);
      instr_start = 1'b0;
      last_ii = int_instr;
      // bounded wait, far above the longest instruction used here
      while (instr_end !== 1'b1 && n < 32'd4000)
      begin
         early = early | (int_take === 1'b1);
         @(negedge ref_clk);
         n = n + 1;
      end
      chk(n, ql * 16);
      chk(early, 1'b0);
      chk(int_take, exp >= 0);
      if (exp >= 0)
         chk(int_source, exp[3:0]);
      last_echo = echo;
      last_grant = shared_grant;
   endtask

   task automatic pulse(input logic [11:0] v);
      raise = v;
      @(negedge ref_clk);
      raise = 12'h000;
   endtask

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_lengths;
      run(PIS_OP_OTHER, 4, -1);
      indirect_levels = 3'h2;
      run(PIS_OP_MEMREF, 16, -1);
      indirect_levels = 3'h0;
      scan_words = 16'h0003;
      run(PIS_OP_SCAN, 20, -1);
      shift_places = 5'h10;
      run(PIS_OP_SHIFT, 37, -1);
      $display("done lengths");
   endtask

   task automatic t_enable;
      pulse(12'h004);
      run(PIS_OP_OTHER, 4, -1);
      run(PIS_OP_ENABLE, 4, -1);
      chk(intr_enabled, 1'b1);
      run(PIS_OP_OTHER, 4, 2);
      run(PIS_OP_OTHER, 5, -1);
      chk(last_ii, 1'b1);
      $display("done enable");
   endtask

   // lower sources raised first, all then drain strictly by rank
   task automatic t_priority;
      int k;
      pulse(12'hf80);
      repeat (8) @(negedge ref_clk);
      pulse(12'h06f);
      prot_enabled = 1'b1;
      prot_write = 1'b1;
      @(negedge ref_clk);
      prot_write = 1'b0;
      for (k = 0; k < 12; k++)
      begin
         run(PIS_OP_OTHER, 4, k);
         chk(last_grant, (k > 6) ? (32'h1 << (k - 7)) : 32'h0);
         run(PIS_OP_OTHER, 5, -1);
      end
      prot_enabled = 1'b0;
      $display("done priority");
   endtask

   task automatic t_inhibit;
      inhibit_count = 8'h02;
      pulse(12'h008);
      run(PIS_OP_INHIBIT, 4, -1);
      run(PIS_OP_OTHER, 4, -1);
      run(PIS_OP_OTHER, 4, 3);
      inhibit_count = 8'h00;
      run(PIS_OP_JST, 9, -1);
      chk(intr_enabled, 1'b0);
      pulse(12'h008);
      run(PIS_OP_OTHER, 4, -1);
      run(PIS_OP_ENABLE, 4, -1);
      run(PIS_OP_DISABLE, 4, -1);
      chk(intr_enabled, 1'b0);
      run(PIS_OP_OTHER, 4, -1);
      $display("done inhibit");
   endtask

   task automatic t_halt;
      halt_pin = 1'b1;
      run(PIS_OP_ENABLE, 4, -1);
      run(PIS_OP_OTHER, 4, -1);
      halt_pin = 1'b0;
      stop_pin = 1'b1;
      run(PIS_OP_OTHER, 4, -1);
      stop_pin = 1'b0;
      run(PIS_OP_OTHER, 4, 3);
      ims_zero = 1'b1;
      run(PIS_OP_IMS, 10, -1);
      chk(last_echo, 1'b1);
      ims_zero = 1'b0;
      // trap latches at console level; a write with protection off raises nothing
      trap_op = 1'b1;
      prot_write = 1'b1;
      @(negedge ref_clk);
      trap_op = 1'b0;
      prot_write = 1'b0;
      run(PIS_OP_OTHER, 4, 1);
      run(PIS_OP_OTHER, 5, -1);
      run(PIS_OP_OTHER, 4, -1);
      $display("done halt");
   endtask

   task automatic t_power;
      run(PIS_OP_DISABLE, 4, -1);
      pf_separate = 1'b1;
      pulse(12'h001);
      run(PIS_OP_OTHER, 4, -1);
      run(PIS_OP_PFE, 4, -1);
      run(PIS_OP_OTHER, 4, 0);
      // power fail raised again so it waits out the auto transfer
      pulse(12'h001);
      run(PIS_OP_AUTO_IO, 19, -1);
      run(PIS_OP_OTHER, 4, 0);
      pf_separate = 1'b0;
      $display("done power");
   endtask

   // ****************************************
   // main sequence and watchdog
   // ****************************************
   initial
   begin
      ref_clk = 1'b0;
      instr_op = PIS_OP_OTHER;
      {nrst, instr_start, ims_zero, trap_op, pf_separate} = '0;
      {prot_enabled, prot_write, halt_pin, stop_pin} = '0;
      {indirect_levels, scan_words, shift_places, inhibit_count, raise} = '0;
      n_errors = 0;
      samples_checked = 0;
      repeat (2) @(negedge ref_clk);
      nrst = 1'b1;
      @(negedge ref_clk);
      chk(busy, 1'b0);
      chk(intr_enabled, 1'b0);
      t_lengths;
      t_enable;
      t_priority;
      t_inhibit;
      t_halt;
      t_power;
      give_verdict;
   end

   // tests need about 5200 cycles; allow 20000 before calling it a hang
   initial
   begin
      #500000;
      n_errors++;
      give_verdict;
   end
endmodule

`default_nettype wire
